// ### hw/ais_pkg.sv
// constants and types shared by the analog input scaler
`default_nettype none
package ais_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ             = 50_000_000;
    localparam int unsigned SAMPLE_PERIOD_US   = 250;
    localparam int unsigned RESULT_PERIOD_US   = 2000;
    localparam int unsigned SAMPLE_CYCLES      = SAMPLE_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SAMPLES_PER_RESULT = RESULT_PERIOD_US / SAMPLE_PERIOD_US;
    localparam int unsigned TICK_W             = 16;
    localparam logic [15:0] TICK_RESET         = 16'h0000;

    // datapath sizes
    localparam int unsigned CHANNELS = 3;
    localparam int unsigned ADC_W    = 12;
    localparam int unsigned SUM_W    = 15;
    localparam int unsigned LP_W     = 14;
    localparam int unsigned RES_W    = 16;
    localparam logic [11:0] ADC_MAX  = 12'hfff;
    // divide by six as multiply by 683 then shift by 12
    localparam logic [9:0]  AVG_RECIP = 10'h2ab;
    localparam logic [2:0]  LAST_SAMPLE = 3'h7;

    // i2c targets and register offsets
    localparam logic [6:0] ADDR_STATUS  = 7'h69;
    localparam logic [6:0] ADDR_CONTROL = 7'h6b;
    localparam logic [7:0] OFS_RANGE    = 8'h08;
    localparam logic [7:0] OFS_CH0      = 8'h14;
    localparam logic [7:0] OFS_CH1      = 8'h16;
    localparam logic [7:0] OFS_CH2      = 8'h18;

    // range select encodings and reset value
    localparam logic [7:0] RANGE_RESET = 8'h00;
    localparam logic [7:0] RANGE_RAW   = 8'hff;
    localparam logic [3:0] NIB_10V     = 4'h1;
    localparam logic [3:0] NIB_20V     = 4'h2;
    localparam logic [3:0] NIB_30V     = 4'h3;

    // full scale in units of 10 mV
    localparam logic [11:0] FS_5V2 = 12'h208;
    localparam logic [11:0] FS_10V = 12'h3e8;
    localparam logic [11:0] FS_20V = 12'h7d0;
    localparam logic [11:0] FS_30V = 12'hbb8;

    typedef enum logic [3:0] {
        AIS_IDLE      = 4'h0,
        AIS_ADDR      = 4'h1,
        AIS_ACK_ADDR  = 4'h3,
        AIS_PTR       = 4'h2,
        AIS_ACK_PTR   = 4'h6,
        AIS_WRITE     = 4'h7,
        AIS_ACK_WRITE = 4'h5,
        AIS_READ      = 4'h4,
        AIS_ACK_READ  = 4'hc
    } ais_bus_state_type;

    typedef struct packed {
        logic [CHANNELS-1:0][ADC_W-1:0] code;
    } ais_adc_in_type;

    typedef struct packed {
        // sampling and filtering
        logic [TICK_W-1:0]              tickCnt;
        logic [2:0]                     sampleIdx;
        logic [CHANNELS-1:0][SUM_W-1:0] sum;
        logic [CHANNELS-1:0][ADC_W-1:0] minCode;
        logic [CHANNELS-1:0][ADC_W-1:0] maxCode;
        logic [CHANNELS-1:0][LP_W-1:0]  lp;
        logic [CHANNELS-1:0][RES_W-1:0] result;
        logic [7:0]                     range;
        logic                           sampleStrobe;
        // i2c target
        ais_bus_state_type              busState;
        logic                           sclQ;
        logic                           sdaQ;
        logic [3:0]                     bitCnt;
        logic [7:0]                     shiftIn;
        logic [7:0]                     shiftOut;
        logic                           isControl;
        logic                           isRead;
        logic                           hiByte;
        logic [7:0]                     pointer;
        logic [RES_W-1:0]               shadow;
        logic                           sdaOe;
        logic                           sdaOut;
    } ais_state_type;
endpackage : ais_pkg
`default_nettype wire

// ### hw/ais_analog_input_scaler.sv
// analog input scaler: sampling, filtering, scaling and its i2c register target
`default_nettype none
module ais_analog_input_scaler
    import ais_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
    input  wire logic           clk_sys,
    input  wire logic           rst_b,
    input  wire ais_adc_in_type adcIn,
    input  wire logic           scl,
    input  wire logic           sdaIn,
    output logic                sdaOut,
    output logic                sdaOe,
    output logic                sampleStrobe
);

    // refuse sample periods the 16-bit tick counter cannot hold
    if (SAMPLE_CYCLES_P < 2 || SAMPLE_CYCLES_P > 65536) begin : g_bad_period
        $error("SAMPLE_CYCLES_P must lie in 2..65536");
    end

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYCLES_P - 1);

    ais_state_type st;
    ais_state_type next_st;

    // full scale of one channel for the current range byte
    function automatic logic [11:0] ais_full_scale(input logic [3:0] nib);
        logic [11:0] fs;
        case (nib)
            NIB_10V: fs = FS_10V;
            NIB_20V: fs = FS_20V;
            NIB_30V: fs = FS_30V;
            default: fs = FS_5V2; // unlisted nibbles fall back to the safe range
        endcase
        return fs;
    endfunction : ais_full_scale

    // binary to four packed decimal digits by shift and add three
    function automatic logic [15:0] ais_to_bcd(input logic [11:0] bin);
        logic [27:0] work;
        work = {16'h0000, bin};
        for (int i = 0; i < 12; i++) begin
            for (int d = 0; d < 4; d++) begin
                if (work[12 + 4*d +: 4] > 4'h4) begin
                    work[12 + 4*d +: 4] = work[12 + 4*d +: 4] + 4'h3;
                end
            end
            work = {work[26:0], 1'b0};
        end
        return work[27:12];
    endfunction : ais_to_bcd

    // next state of sampler, filters and i2c target
    always_comb begin
        logic              tick;
        logic              sclRise;
        logic              sclFall;
        logic              startCond;
        logic              stopCond;
        logic [ADC_W-1:0]  code;
        logic [SUM_W-1:0]  trim;
        logic [24:0]       prod;
        logic [ADC_W-1:0]  avg;
        logic [SUM_W-1:0]  lpSum;
        logic [ADC_W-1:0]  filtered;
        logic [11:0]       fs;
        logic [23:0]       scaled;
        logic [7:0]        loadByte;
        tick      = 1'b0;
        sclRise   = 1'b0;
        sclFall   = 1'b0;
        startCond = 1'b0;
        stopCond  = 1'b0;
        code      = '0;
        trim      = '0;
        prod      = '0;
        avg       = '0;
        lpSum     = '0;
        filtered  = '0;
        fs        = '0;
        scaled    = '0;
        loadByte  = '0;
        next_st   = st;

        // free-running sample tick, no host request needed
        tick                 = (st.tickCnt == TICK_LAST);
        next_st.tickCnt      = tick ? TICK_RESET : st.tickCnt + 16'h0001;
        next_st.sampleStrobe = tick;
        next_st.sdaOut       = 1'b0;

        // gather eight samples, then trim, low-pass and publish
        if (tick) begin
            next_st.sampleIdx = (st.sampleIdx == LAST_SAMPLE) ? 3'h0 : st.sampleIdx + 3'h1;
            for (int ch = 0; ch < CHANNELS; ch++) begin
                code = adcIn.code[ch];
                if (st.sampleIdx == 3'h0) begin
                    next_st.sum[ch]     = SUM_W'(code);
                    next_st.minCode[ch] = code;
                    next_st.maxCode[ch] = code;
                end else begin
                    next_st.sum[ch] = st.sum[ch] + SUM_W'(code);
                    if (code < st.minCode[ch]) begin
                        next_st.minCode[ch] = code;
                    end
                    if (code > st.maxCode[ch]) begin
                        next_st.maxCode[ch] = code;
                    end
                end
                if (st.sampleIdx == LAST_SAMPLE) begin
                    // drop highest and lowest, average the remaining six
                    trim = next_st.sum[ch] - SUM_W'(next_st.minCode[ch])
                         - SUM_W'(next_st.maxCode[ch]);
                    prod = 25'(trim) * 25'(AVG_RECIP);
                    avg  = (prod[24:12] > 13'(ADC_MAX)) ? ADC_MAX : prod[23:12];
                    // first-order low-pass, two fraction bits kept
                    lpSum       = SUM_W'(st.lp[ch]) + SUM_W'({avg, 2'b00});
                    next_st.lp[ch] = lpSum[SUM_W-1:1];
                    filtered    = lpSum[SUM_W-1:3];
                    case (ch)
                        1:       fs = ais_full_scale(st.range[7:4]);
                        2:       fs = ais_full_scale(st.range[3:0]);
                        default: fs = FS_5V2;
                    endcase
                    scaled = 24'(filtered) * 24'(fs);
                    if (st.range == RANGE_RAW) begin
                        next_st.result[ch] = RES_W'(filtered);
                    end else begin
                        next_st.result[ch] = ais_to_bcd(scaled[23:12]);
                    end
                end
            end
        end

        // bus edges; pins are already synchronous, one stage for edges
        next_st.sclQ = scl;
        next_st.sdaQ = sdaIn;
        sclRise   = scl & ~st.sclQ;
        sclFall   = ~scl & st.sclQ;
        startCond = scl & st.sclQ & st.sdaQ & ~sdaIn;
        stopCond  = scl & st.sclQ & ~st.sdaQ & sdaIn;

        if (stopCond) begin
            next_st.busState = AIS_IDLE;
            next_st.sdaOe    = 1'b0;
        end else if (startCond) begin
            next_st.busState = AIS_ADDR;
            next_st.bitCnt   = 4'h0;
            next_st.sdaOe    = 1'b0;
        end else begin
            case (st.busState)
                AIS_ADDR, AIS_PTR, AIS_WRITE: begin
                    if (sclRise) begin
                        next_st.shiftIn = {st.shiftIn[6:0], sdaIn};
                        next_st.bitCnt  = st.bitCnt + 4'h1;
                    end else if (sclFall && st.bitCnt == 4'h8) begin
                        next_st.bitCnt = 4'h0;
                        next_st.sdaOe  = 1'b1;
                        if (st.busState == AIS_ADDR) begin
                            next_st.isControl = (st.shiftIn[7:1] == ADDR_CONTROL);
                            next_st.isRead    = st.shiftIn[0];
                            next_st.hiByte    = 1'b0;
                            next_st.busState  = AIS_ACK_ADDR;
                            // whole word frozen here so bytes stay coherent
                            if (st.shiftIn[7:1] == ADDR_STATUS) begin
                                case (st.pointer)
                                    OFS_CH0: next_st.shadow = st.result[0];
                                    OFS_CH1: next_st.shadow = st.result[1];
                                    OFS_CH2: next_st.shadow = st.result[2];
                                    default: next_st.shadow = 16'h0000;
                                endcase
                            end else if (st.shiftIn[7:1] == ADDR_CONTROL) begin
                                next_st.shadow = (st.pointer == OFS_RANGE)
                                               ? {8'h00, st.range} : 16'h0000;
                            end else begin
                                next_st.sdaOe    = 1'b0; // not ours, stay silent
                                next_st.busState = AIS_IDLE;
                            end
                        end else if (st.busState == AIS_PTR) begin
                            next_st.pointer  = st.shiftIn;
                            next_st.busState = AIS_ACK_PTR;
                        end else begin
                            if (st.isControl && st.pointer == OFS_RANGE) begin
                                next_st.range = st.shiftIn;
                            end
                            next_st.pointer  = st.pointer + 8'h01;
                            next_st.busState = AIS_ACK_WRITE;
                        end
                    end
                end
                AIS_ACK_ADDR, AIS_ACK_PTR, AIS_ACK_WRITE: begin
                    if (sclFall) begin
                        loadByte         = st.shadow[7:0];
                        next_st.sdaOe    = 1'b0;
                        next_st.busState = (st.busState == AIS_ACK_ADDR) ? AIS_PTR : AIS_WRITE;
                        if (st.busState == AIS_ACK_ADDR && st.isRead) begin
                            next_st.shiftOut = loadByte;
                            next_st.sdaOe    = ~loadByte[7];
                            next_st.busState = AIS_READ;
                        end
                    end
                end
                AIS_READ: begin
                    if (sclRise) begin
                        next_st.bitCnt = st.bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (st.bitCnt == 4'h8) begin
                            next_st.bitCnt   = 4'h0;
                            next_st.sdaOe    = 1'b0;
                            next_st.hiByte   = ~st.hiByte;
                            next_st.busState = AIS_ACK_READ;
                        end else begin
                            next_st.shiftOut = {st.shiftOut[6:0], 1'b0};
                            next_st.sdaOe    = ~st.shiftOut[6];
                        end
                    end
                end
                AIS_ACK_READ: begin
                    if (sclRise && sdaIn) begin
                        next_st.busState = AIS_IDLE; // host ended the read
                    end else if (sclFall) begin
                        // low byte first, then high byte of the frozen word
                        loadByte         = st.hiByte ? st.shadow[15:8] : st.shadow[7:0];
                        next_st.shiftOut = loadByte;
                        next_st.sdaOe    = ~loadByte[7];
                        next_st.busState = AIS_READ;
                    end
                end
                default: begin
                    next_st.sdaOe = 1'b0;
                end
            endcase
        end
    end

    // single state register; results clear to zero until the first publish
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st          <= '0;
            st.tickCnt  <= TICK_RESET;
            st.range    <= RANGE_RESET;
            st.busState <= AIS_IDLE;
            st.sclQ     <= 1'b1;
            st.sdaQ     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign sdaOut       = st.sdaOut;
    assign sdaOe        = st.sdaOe;
    assign sampleStrobe = st.sampleStrobe;

endmodule : ais_analog_input_scaler
`default_nettype wire

// ### test/ais_i2c_host.sv
// i2c host model that reads and writes the scaler registers
`default_nettype none
module ais_i2c_host (
    input  wire logic clk_sys,
    input  wire logic sdaBus,
    output var logic  scl,
    output var logic  sdaDrv
);
    timeunit 1ns;
    timeprecision 1ns;

    // both lines released at time zero, pulled high
    initial begin
        scl    = 1'b1;
        sdaDrv = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : hold

    // one clock-line period, four cycles low and five high, above the three-cycle minimum
    // data moves in the low phase; dHigh differs from dLow only for start and stop
    task automatic pulse(input logic dLow, input logic dHigh, output logic got);
        scl <= 1'b0;
        hold(2);
        sdaDrv <= dLow;
        hold(2);
        scl <= 1'b1;
        hold(3);
        got = sdaBus;
        sdaDrv <= dHigh;
        hold(2);
    endtask : pulse

    // msb first, then the ninth bit released so the target can answer
    task automatic putByte(input logic [7:0] d, output logic ok);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            pulse(d[i], d[i], g);
        end
        pulse(1'b1, 1'b1, g);
        ok = ~g;
    endtask : putByte

    task automatic getByte(input logic last, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b1, 1'b1, d[i]);
        end
        pulse(last, last, g); // nack on the last byte ends the read
    endtask : getByte

    task automatic writeReg(input logic [6:0] a, input logic [7:0] o, input logic [7:0] v,
                            output logic ok);
        logic g;
        logic a1;
        logic a2;
        logic a3;
        pulse(1'b1, 1'b0, g);
        putByte({a, 1'b0}, a1);
        putByte(o, a2);
        putByte(v, a3);
        pulse(1'b0, 1'b1, g);
        ok = a1 & a2 & a3;
    endtask : writeReg

    // pointer write, repeated start, then low byte before high byte
    task automatic readWord(input logic [6:0] a, input logic [7:0] o, output logic [15:0] w,
                            output logic ok);
        logic g;
        logic a1;
        logic a2;
        logic a3;
        pulse(1'b1, 1'b0, g);
        putByte({a, 1'b0}, a1);
        putByte(o, a2);
        pulse(1'b1, 1'b0, g);
        putByte({a, 1'b1}, a3);
        getByte(1'b0, w[7:0]);
        getByte(1'b1, w[15:8]);
        pulse(1'b0, 1'b1, g);
        ok = a1 & a2 & a3;
    endtask : readWord
endmodule : ais_i2c_host
`default_nettype wire

// ### test/ais_scaler_monitor.sv
// port checks for the analog input scaler
`default_nettype none
module ais_scaler_monitor
    import ais_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic sampleStrobe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // cycles since the last strobe; a counter because the period is far beyond unrolling
    int unsigned gap;
    logic        seen;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gap  <= 0;
            seen <= 1'b0;
        end else begin
            gap  <= sampleStrobe ? 0 : gap + 1;
            seen <= seen | sampleStrobe;
        end
    end

    // bus conditions: data line moves while the clock line is high
    sequence seqStart;
        scl && $past(scl) && $fell(sdaIn);
    endsequence
    sequence seqStop;
        scl && $past(scl) && $rose(sdaIn);
    endsequence

    AST_STROBE_PULSE: assert property (sampleStrobe |=> !sampleStrobe)
        else $error("strobe wider than one cycle");
    AST_STROBE_PERIOD: assert property (sampleStrobe && seen |-> gap == SAMPLE_CYCLES_P - 1)
        else $error("strobe spacing wrong");
    AST_STROBE_NOT_LATE: assert property (seen |-> gap < SAMPLE_CYCLES_P)
        else $error("strobe missing");
    AST_RESET_QUIET: assert property ($rose(rst_b) |-> !sdaOe && !sampleStrobe)
        else $error("outputs active at reset release");
    AST_OPEN_DRAIN: assert property (sdaOe |-> !sdaOut)
        else $error("data line driven high");
    AST_ADDR_QUIET: assert property (seqStart |=> !sdaOe [*8])
        else $error("target drove during address bits");
    AST_STOP_RELEASE: assert property (seqStop |=> !sdaOe [*8])
        else $error("target drove after stop");
    AST_OE_STEADY: assert property (scl && $past(scl) |-> $stable(sdaOe))
        else $error("data changed while clock high");
    AST_OE_LOW_PHASE: assert property ($rose(sdaOe) |-> !scl && !$past(scl))
        else $error("drive started outside low phase");
endmodule : ais_scaler_monitor

bind ais_analog_input_scaler ais_scaler_monitor #(
    .SAMPLE_CYCLES_P(SAMPLE_CYCLES_P)
) u_ais_scaler_monitor (
    .clk_sys(clk_sys), .rst_b(rst_b), .scl(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .sampleStrobe(sampleStrobe)
);
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the analog input scaler
`default_nettype none
module tb_top
    import ais_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned SC = 20; // short sample period keeps the run brief
    typedef struct packed {
        logic [7:0]  rng;
        logic [11:0] fs1;
        logic [11:0] fs2;
    } ais_row_type;
    // range byte and full scales of channels 1 and 2; zero full scale means raw codes
    // unlisted nibbles such as 4 and e must fall back to the 5.2 v range
    localparam ais_row_type ROWS [6] = '{'{8'h00, FS_5V2, FS_5V2}, '{8'h13, FS_10V, FS_30V},
        '{8'h21, FS_20V, FS_10V}, '{8'h32, FS_30V, FS_20V}, '{8'h4e, FS_5V2, FS_5V2},
        '{8'hff, 12'h000, 12'h000}};
    logic           clk_sys;
    logic           rst_b;
    ais_adc_in_type adcIn;
    logic           scl;
    logic           sdaDrv;
    logic           sdaOut;
    logic           sdaOe;
    logic           sampleStrobe;
    logic [15:0]    word;
    logic           ack;
    int             mismatches;
    int             checked;
    wire logic      sdaBus;

    // open-drain wire, low when either side pulls
    assign sdaBus = sdaDrv & ~(sdaOe & ~sdaOut);

    ais_analog_input_scaler #(.SAMPLE_CYCLES_P(SC)) u_ais_analog_input_scaler (
        .clk_sys(clk_sys), .rst_b(rst_b), .adcIn(adcIn), .scl(scl), .sdaIn(sdaBus),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .sampleStrobe(sampleStrobe));
    ais_i2c_host u_ais_i2c_host (.clk_sys(clk_sys), .sdaBus(sdaBus), .scl(scl), .sdaDrv(sdaDrv));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // settled filter output for a steady code, then scaled to packed decimal
    function automatic logic [15:0] want(input logic [11:0] a, input logic [11:0] fs);
        logic [31:0] avg;
        logic [31:0] lp;
        logic [31:0] v;
        avg = (32'(a) * 32'd4098) >> 12; // six kept samples times 683
        avg = (avg > 32'd4095) ? 32'd4095 : avg;
        lp = 32'h0;
        repeat (40) lp = (lp + 4 * avg) >> 1;
        v = ((lp >> 2) * 32'(fs)) >> 12;
        return (fs == 12'h000) ? 16'(lp >> 2)
            : {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction : want

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    task automatic rd(input logic [6:0] a, input logic [7:0] o, input logic [15:0] exp);
        u_ais_i2c_host.readWord(a, o, word, ack);
        check({15'h0, ack}, 16'h0001);
        check(word, exp);
    endtask : rd

    task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] v,
                      input logic ok);
        u_ais_i2c_host.writeReg(a, o, v, ack);
        check({15'h0, ack}, {15'h0, ok});
    endtask : wr

    // bounded wait for strobes, sampled on the falling edge where they are settled
    task automatic waitStrobes(input int n);
        int cnt;
        int t;
        cnt = 0;
        t = 0;
        while (cnt < n && t < n * SC * 2) begin
            @(negedge clk_sys);
            t++;
            cnt += (sampleStrobe === 1'b1) ? 1 : 0;
        end
        @(posedge clk_sys); // callers drive the bus from the rising edge
        if (cnt < n) begin
            mismatches++;
            give_verdict();
        end
    endtask : waitStrobes

    task automatic pulseReset(input int n);
        rst_b <= 1'b0;
        repeat (n) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask : pulseReset

    initial begin
        rst_b = 1'b0;
        adcIn = {12'h123, 12'hfff, 12'h800};
        mismatches = 0;
        checked = 0;
        pulseReset(10);
        rd(ADDR_CONTROL, OFS_RANGE, {8'h00, RANGE_RESET});
        waitStrobes(200);
        foreach (ROWS[i]) begin
            wr(ADDR_CONTROL, OFS_RANGE, ROWS[i].rng, 1'b1);
            waitStrobes(16);
            rd(ADDR_CONTROL, OFS_RANGE, {8'h00, ROWS[i].rng});
            rd(ADDR_STATUS, OFS_CH0, want(12'h800, ROWS[i].fs1 == 0 ? 12'h0 : FS_5V2));
            rd(ADDR_STATUS, OFS_CH1, want(12'hfff, ROWS[i].fs1));
            rd(ADDR_STATUS, OFS_CH2, want(12'h123, ROWS[i].fs2));
        end
        // unmapped offsets, a foreign address, then a reset in mid-run
        wr(ADDR_CONTROL, 8'h09, 8'h55, 1'b1);
        rd(ADDR_CONTROL, OFS_RANGE, {8'h00, RANGE_RAW});
        rd(ADDR_STATUS, 8'h10, 16'h0000);
        wr(7'h6a, OFS_RANGE, 8'h00, 1'b0);
        rd(ADDR_CONTROL, OFS_RANGE, {8'h00, RANGE_RAW});
        pulseReset(3);
        rd(ADDR_CONTROL, OFS_RANGE, {8'h00, RANGE_RESET});
        waitStrobes(8);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
